// ==== design/ufc_pkg.sv ====
package ufc_pkg;
  // Register byte addresses on the bus; one byte per aligned word.
  localparam logic [5:0] ADR_DATA = 6'h00;
  localparam logic [5:0] ADR_IER = 6'h04;
  localparam logic [5:0] ADR_ISR_FCR = 6'h08;
  localparam logic [5:0] ADR_LCR = 6'h0C;
  localparam logic [5:0] ADR_MCR = 6'h10;
  localparam logic [5:0] ADR_LSR = 6'h14;
  localparam logic [5:0] ADR_EFR = 6'h18;
  localparam logic [5:0] ADR_FEATURE_CONTROL_REGISTER = 6'h1C;
  localparam logic [5:0] ADR_RECEIVE_TRIGGER_REGISTER = 6'h20;
  localparam logic [5:0] ADR_TRANSMIT_TRIGGER_REGISTER = 6'h24;
  // Field positions.
  localparam int FCR_EN = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int EFR_ENH = 4;
  localparam int MCR_PRESC = 7;
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LS = 2;
  localparam int IER_MS = 3;
  localparam int IER_XOFF = 5;
  localparam int IER_RTS = 6;
  localparam int IER_CTS = 7;
  // Interrupt source codes in priority order.
  localparam logic [5:0] ISR_LSR = 6'h06;
  localparam logic [5:0] ISR_RECEIVE_READY_PIN = 6'h04;
  localparam logic [5:0] ISR_RXTO = 6'h0C;
  localparam logic [5:0] ISR_TRANSMIT_READY_PIN = 6'h02;
  localparam logic [5:0] ISR_MSR = 6'h00;
  localparam logic [5:0] ISR_SPECIAL = 6'h10;
  localparam logic [5:0] ISR_FLOW = 6'h20;
  localparam logic [5:0] ISR_NONE = 6'h01;
  // FIFO geometry.
  localparam int FIFO_DEPTH = 64;
  localparam logic [6:0] FIFO_FULL = 7'h40;
  // Trigger tables, indexed by the two select bits.
  localparam logic [7:0] TRG_ONE = 8'h01;
  localparam logic [7:0] TRG_A_RX [4] = '{8'h01, 8'h04, 8'h08, 8'h0E};
  localparam logic [7:0] TRG_B_RX [4] = '{8'h08, 8'h10, 8'h18, 8'h1C};
  localparam logic [7:0] TRG_B_TX [4] = '{8'h10, 8'h08, 8'h18, 8'h1E};
  localparam logic [7:0] TRG_C_RX [4] = '{8'h08, 8'h10, 8'h38, 8'h3C};
  localparam logic [7:0] TRG_C_TX [4] = '{8'h08, 8'h10, 8'h20, 8'h38};
  localparam logic [1:0] TBL_A = 2'h0;
  localparam logic [1:0] TBL_B = 2'h1;
  localparam logic [1:0] TBL_C = 2'h2;
  // Serial timing in oversample ticks.
  localparam logic [5:0] BIT_TICKS = 6'h10;
  localparam logic [5:0] STOP_ONE = 6'h10;
  localparam logic [5:0] STOP_HALF = 6'h18;
  localparam logic [5:0] STOP_TWO = 6'h20;
  localparam logic [3:0] SAMPLE_PT = 4'h7;
  localparam logic [2:0] FIRST_LAST_BIT = 3'h4;
  localparam logic [1:0] PRESC_LAST = 2'h3;
  localparam int RX_TO_BITS = 52;
  localparam int OVS = 16;
  localparam logic [9:0] RX_TO_TICKS = 10'(RX_TO_BITS * OVS);
  // Reset values.
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] DLL_RST = 8'h01;
  typedef struct packed {
    logic dlab;
    logic brk;
    logic par_force;
    logic par_even;
    logic par_en;
    logic stop_long;
    logic [1:0] wlen;
  } ufc_lcr_s;
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} ufc_ser_e;
endpackage

// ==== design/ufc_top.sv ====
`timescale 1ns/1ns
`default_nettype none

module ufc_fifo (
  input wire logic clock,
  input wire logic resetn,
  input wire logic flush,
  input wire logic deep,
  input wire logic push,
  input wire logic [7:0] wdata,
  input wire logic pop,
  output logic [7:0] rdata,
  output logic [6:0] count,
  output logic full
);
  logic [7:0] mem_q [ufc_pkg::FIFO_DEPTH];
  logic [5:0] wp_q;
  logic [5:0] rp_q;
  logic [6:0] cnt_q;
  logic do_push;
  logic do_pop;

  // Without FIFO mode the store acts as a single holding register.
  assign full = deep ? (cnt_q == ufc_pkg::FIFO_FULL) : (cnt_q != 7'h00);
  assign do_push = push & ~full;
  assign do_pop = pop & (cnt_q != 7'h00);
  assign rdata = mem_q[rp_q];
  assign count = cnt_q;

  // A flush clears pointers and level only; stored bytes are left as they are.
  always_ff @(posedge clock) begin
    if (!resetn || flush) begin
      wp_q <= 6'h00;
      rp_q <= 6'h00;
      cnt_q <= 7'h00;
    end else begin
      if (do_push) wp_q <= wp_q + 6'h01;
      if (do_pop) rp_q <= rp_q + 6'h01;
      cnt_q <= cnt_q + 7'(do_push) - 7'(do_pop);
    end
  end

  // Storage needs no reset: an entry is read only after it was written.
  always_ff @(posedge clock) begin
    if (do_push) mem_q[wp_q] <= wdata;
  end
endmodule

module ufc_top (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxd,
  output logic txd,
  input wire logic modem_status_evt,
  input wire logic special_char_evt,
  input wire logic flow_pin_evt
);
  ufc_pkg::ufc_lcr_s lcr_q;
  logic [7:0] ier_q, mcr_q, efr_q, feature_control_register_q, receive_trigger_register_q, transmit_trigger_register_q, dll_q, dlm_q, dld_q;
  logic fifo_en_q, ack_q, txd_q, tx_rdy_q;
  logic [1:0] rx_sel_q, tx_sel_q;
  logic [31:0] dat_q;

  function automatic logic hit(input logic [5:0] adr, input logic [5:0] reg_adr);
    return adr == reg_adr;
  endfunction

  // Parity for the active word length; unused high bits are masked off here.
  function automatic logic par_bit(input logic [7:0] d, input ufc_pkg::ufc_lcr_s l);
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - l.wlen));
    if (l.par_force) return ~l.par_even;
    return (^m) ^ ~l.par_even;
  endfunction

  // Bus decode. A request is taken once, on the edge that raises ack.
  logic acc, wr, rd, dlab;
  logic [7:0] wd;
  logic s_data, s_ier, s_isr, s_lcr, s_mcr, s_lsr, s_efr, s_feature_control_register, s_receive_trigger_register, s_transmit_trigger_register;
  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign rd = acc & ~wb_we_i;
  assign wd = wb_dat_i[7:0];
  assign dlab = lcr_q.dlab;
  assign s_data = hit(wb_adr_i, ufc_pkg::ADR_DATA);
  assign s_ier = hit(wb_adr_i, ufc_pkg::ADR_IER);
  assign s_isr = hit(wb_adr_i, ufc_pkg::ADR_ISR_FCR);
  assign s_lcr = hit(wb_adr_i, ufc_pkg::ADR_LCR);
  assign s_mcr = hit(wb_adr_i, ufc_pkg::ADR_MCR);
  assign s_lsr = hit(wb_adr_i, ufc_pkg::ADR_LSR);
  assign s_efr = hit(wb_adr_i, ufc_pkg::ADR_EFR);
  assign s_feature_control_register = hit(wb_adr_i, ufc_pkg::ADR_FEATURE_CONTROL_REGISTER);
  assign s_receive_trigger_register = hit(wb_adr_i, ufc_pkg::ADR_RECEIVE_TRIGGER_REGISTER);
  assign s_transmit_trigger_register = hit(wb_adr_i, ufc_pkg::ADR_TRANSMIT_TRIGGER_REGISTER);

  // The divisor access bit steers the first three addresses to the latches.
  logic wr_thr, wr_dll, wr_dlm, wr_dld, wr_ier, wr_fcr, wr_mcr, rd_rhr, rd_isr, rd_lsr;
  assign wr_thr = wr & s_data & ~dlab;
  assign wr_dll = wr & s_data & dlab;
  assign wr_dlm = wr & s_ier & dlab;
  assign wr_ier = wr & s_ier & ~dlab;
  assign wr_dld = wr & s_isr & dlab;
  assign wr_fcr = wr & s_isr & ~dlab;
  assign wr_mcr = wr & s_mcr;
  assign rd_rhr = rd & s_data & ~dlab;
  assign rd_isr = rd & s_isr & ~dlab;
  assign rd_lsr = rd & s_lsr;

  // A control write with the enable bit clear only disables the FIFOs.
  logic fcr_take, rx_flush, tx_flush;
  assign fcr_take = wr_fcr & wd[ufc_pkg::FCR_EN];
  assign rx_flush = fcr_take & wd[ufc_pkg::FCR_RXRST];
  assign tx_flush = fcr_take & wd[ufc_pkg::FCR_TXRST];
  // The DMA mode bit is accepted and dropped; no ready pins exist.

  // Trigger levels; one table selector serves both directions.
  logic [1:0] tbl;
  logic [7:0] rx_trig_t, tx_trig_t, rx_trig, tx_trig;
  assign tbl = feature_control_register_q[7:6];
  assign rx_trig_t = (tbl == ufc_pkg::TBL_A) ? ufc_pkg::TRG_A_RX[rx_sel_q] :
    (tbl == ufc_pkg::TBL_B) ? ufc_pkg::TRG_B_RX[rx_sel_q] :
    (tbl == ufc_pkg::TBL_C) ? ufc_pkg::TRG_C_RX[rx_sel_q] : receive_trigger_register_q;
  assign tx_trig_t = (tbl == ufc_pkg::TBL_A) ? ufc_pkg::TRG_ONE :
    (tbl == ufc_pkg::TBL_B) ? ufc_pkg::TRG_B_TX[tx_sel_q] :
    (tbl == ufc_pkg::TBL_C) ? ufc_pkg::TRG_C_TX[tx_sel_q] : transmit_trigger_register_q;
  assign rx_trig = fifo_en_q ? rx_trig_t : ufc_pkg::TRG_ONE;
  assign tx_trig = fifo_en_q ? tx_trig_t : ufc_pkg::TRG_ONE;

  // Baud tick: optional divide-by-four prescaler, then the 16-bit divisor.
  logic [1:0] pre_q;
  logic [15:0] div_q, divisor;
  logic pre_tick, tick;
  assign pre_tick = ~mcr_q[ufc_pkg::MCR_PRESC] | (pre_q == ufc_pkg::PRESC_LAST);
  assign divisor = {dlm_q, dll_q};
  assign tick = pre_tick & (div_q <= 16'h0001);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pre_q <= 2'h0;
      div_q <= 16'h0000;
    end else begin
      pre_q <= pre_q + 2'h1;
      if (pre_tick) div_q <= tick ? divisor : div_q - 16'h0001;
    end
  end

  // The two 64-entry stores with their level counters.
  logic [7:0] rx_head, tx_head, rx_sh_q;
  logic [6:0] rx_cnt, tx_cnt;
  logic rx_full, rx_done, tx_load;
  ufc_fifo u_rx_fifo (
    .clock(clock),
    .resetn(resetn),
    .flush(rx_flush),
    .deep(fifo_en_q),
    .push(rx_done),
    .wdata(rx_sh_q),
    .pop(rd_rhr),
    .rdata(rx_head),
    .count(rx_cnt),
    .full(rx_full)
  );
  ufc_fifo u_tx_fifo (
    .clock(clock),
    .resetn(resetn),
    .flush(tx_flush),
    .deep(fifo_en_q),
    .push(wr_thr),
    .wdata(wd),
    .pop(tx_load),
    .rdata(tx_head),
    .count(tx_cnt),
    .full()
  );

  // Transmit framing: start, data, optional parity, stop.
  ufc_pkg::ufc_ser_e tx_st_q, rx_st_q;
  logic [7:0] tx_sh_q;
  logic [2:0] tx_bit_q, last_bit;
  logic [5:0] tx_sub_q, stop_span, tx_span;
  logic tx_end, tx_line;
  assign last_bit = ufc_pkg::FIRST_LAST_BIT + {1'b0, lcr_q.wlen};
  assign stop_span = !lcr_q.stop_long ? ufc_pkg::STOP_ONE :
    (lcr_q.wlen == 2'h0) ? ufc_pkg::STOP_HALF : ufc_pkg::STOP_TWO;
  assign tx_span = (tx_st_q == ufc_pkg::S_STOP) ? stop_span : ufc_pkg::BIT_TICKS;
  assign tx_end = tick & (tx_sub_q == tx_span - 6'h01);
  assign tx_load = (tx_st_q == ufc_pkg::S_IDLE) & (tx_cnt != 7'h00);
  assign tx_line = (tx_st_q == ufc_pkg::S_START) ? 1'b0 :
    (tx_st_q == ufc_pkg::S_DATA) ? tx_sh_q[tx_bit_q] :
    (tx_st_q == ufc_pkg::S_PAR) ? par_bit(tx_sh_q, lcr_q) : 1'b1;

  // The shifter is loaded only from the store, so a flush never touches it.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_st_q <= ufc_pkg::S_IDLE;
      tx_sh_q <= 8'h00;
      tx_bit_q <= 3'h0;
      tx_sub_q <= 6'h00;
    end else if (tx_load) begin
      tx_st_q <= ufc_pkg::S_START;
      tx_sh_q <= tx_head;
      tx_sub_q <= 6'h00;
    end else if (tick && tx_st_q != ufc_pkg::S_IDLE) begin
      tx_sub_q <= tx_end ? 6'h00 : tx_sub_q + 6'h01;
      if (tx_end) begin
        unique case (tx_st_q)
          ufc_pkg::S_START: begin
            tx_st_q <= ufc_pkg::S_DATA;
            tx_bit_q <= 3'h0;
          end
          ufc_pkg::S_DATA: begin
            if (tx_bit_q == last_bit) begin
              tx_st_q <= lcr_q.par_en ? ufc_pkg::S_PAR : ufc_pkg::S_STOP;
            end else begin
              tx_bit_q <= tx_bit_q + 3'h1;
            end
          end
          ufc_pkg::S_PAR: tx_st_q <= ufc_pkg::S_STOP;
          default: tx_st_q <= ufc_pkg::S_IDLE;
        endcase
      end
    end
  end

  // Receive: every state except idle acts at the middle of its bit; idle starts on any low tick.
  logic [2:0] rx_bit_q;
  logic [3:0] rx_sub_q;
  logic rx_pbit_q, rx_mid, rx_perr, rx_brk;
  assign rx_mid = tick & (rx_sub_q == ufc_pkg::SAMPLE_PT);
  assign rx_done = rx_mid & (rx_st_q == ufc_pkg::S_STOP);
  assign rx_perr = lcr_q.par_en & (rx_pbit_q != par_bit(rx_sh_q, lcr_q));
  assign rx_brk = ~rxd & (rx_sh_q == 8'h00) & ~(lcr_q.par_en & rx_pbit_q);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rx_st_q <= ufc_pkg::S_IDLE;
      rx_sh_q <= 8'h00;
      rx_bit_q <= 3'h0;
      rx_sub_q <= 4'h0;
      rx_pbit_q <= 1'b0;
    end else if (tick) begin
      rx_sub_q <= (rx_st_q == ufc_pkg::S_IDLE) ? 4'h0 : rx_sub_q + 4'h1;
      if (rx_st_q == ufc_pkg::S_IDLE && !rxd) begin
        rx_st_q <= ufc_pkg::S_START;
        rx_sh_q <= 8'h00;
      end else if (rx_mid) begin
        unique case (rx_st_q)
          ufc_pkg::S_START: begin
            rx_st_q <= rxd ? ufc_pkg::S_IDLE : ufc_pkg::S_DATA;
            rx_bit_q <= 3'h0;
          end
          ufc_pkg::S_DATA: begin
            rx_sh_q[rx_bit_q] <= rxd;
            if (rx_bit_q == last_bit) begin
              rx_st_q <= lcr_q.par_en ? ufc_pkg::S_PAR : ufc_pkg::S_STOP;
            end else begin
              rx_bit_q <= rx_bit_q + 3'h1;
            end
          end
          ufc_pkg::S_PAR: begin
            rx_pbit_q <= rxd;
            rx_st_q <= ufc_pkg::S_STOP;
          end
          default: rx_st_q <= ufc_pkg::S_IDLE;
        endcase
      end
    end
  end

  // Sticky line errors {break, framing, parity, overrun}; a new error beats the read clear.
  logic [3:0] err_q;
  logic [9:0] to_q;
  logic to_flag, tx_fall;
  assign to_flag = (to_q == ufc_pkg::RX_TO_TICKS);
  // The ready event fires on the pop that drops the level below the trigger or empties the store.
  assign tx_fall = tx_load & ~wr_thr & (({1'b0, tx_cnt} == tx_trig) | (tx_cnt == 7'h01));

  always_ff @(posedge clock) begin
    if (!resetn) begin
      err_q <= 4'h0;
      to_q <= 10'h000;
      tx_rdy_q <= 1'b0;
    end else begin
      err_q <= (rd_lsr ? 4'h0 : err_q) | (rx_done ? {rx_brk, ~rxd, rx_perr, rx_full} : 4'h0);
      if (rd_rhr || rx_cnt == 7'h00 || rx_st_q != ufc_pkg::S_IDLE) to_q <= 10'h000;
      else if (tick && !to_flag) to_q <= to_q + 10'h001;
      tx_rdy_q <= (tx_rdy_q & ~(rd_isr | wr_thr)) | tx_fall;
    end
  end

  // Interrupt sources in priority order.
  logic ls_int, rxr_int, to_int, tx_int, ms_int, sp_int, fl_int;
  logic [5:0] isr_code;
  logic [7:0] interrupt_source_status, line_status_register, rd_d;
  assign ls_int = ier_q[ufc_pkg::IER_LS] & (err_q != 4'h0);
  assign rxr_int = ier_q[ufc_pkg::IER_RX] & ({1'b0, rx_cnt} >= rx_trig);
  assign to_int = ier_q[ufc_pkg::IER_RX] & to_flag;
  assign tx_int = ier_q[ufc_pkg::IER_TX] & tx_rdy_q;
  assign ms_int = ier_q[ufc_pkg::IER_MS] & modem_status_evt;
  assign sp_int = ier_q[ufc_pkg::IER_XOFF] & special_char_evt;
  assign fl_int = (ier_q[ufc_pkg::IER_RTS] | ier_q[ufc_pkg::IER_CTS]) & flow_pin_evt;
  assign isr_code = ls_int ? ufc_pkg::ISR_LSR : rxr_int ? ufc_pkg::ISR_RECEIVE_READY_PIN :
    to_int ? ufc_pkg::ISR_RXTO : tx_int ? ufc_pkg::ISR_TRANSMIT_READY_PIN :
    ms_int ? ufc_pkg::ISR_MSR : sp_int ? ufc_pkg::ISR_SPECIAL :
    fl_int ? ufc_pkg::ISR_FLOW : ufc_pkg::ISR_NONE;
  assign interrupt_source_status = {fifo_en_q, fifo_en_q, isr_code};
  assign line_status_register = {err_q[3:1] != 3'h0, (tx_cnt == 7'h00) & (tx_st_q == ufc_pkg::S_IDLE),
    tx_cnt == 7'h00, err_q, rx_cnt != 7'h00};

  // Read mux; unmapped addresses read zero.
  assign rd_d = s_data ? (dlab ? dll_q : rx_head) :
    s_ier ? (dlab ? dlm_q : ier_q) :
    s_isr ? (dlab ? dld_q : interrupt_source_status) :
    s_lcr ? lcr_q : s_mcr ? mcr_q : s_lsr ? line_status_register : s_efr ? efr_q :
    s_feature_control_register ? feature_control_register_q : s_receive_trigger_register ? receive_trigger_register_q : s_transmit_trigger_register ? transmit_trigger_register_q : 8'h00;

  // Break forces the line low whatever the framer is doing.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      txd_q <= 1'b1;
    end else begin
      ack_q <= acc;
      dat_q <= rd ? {24'h000000, rd_d} : 32'h00000000;
      txd_q <= ~lcr_q.brk & tx_line;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign txd = txd_q;

  // Register writes.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      lcr_q <= ufc_pkg::REG_RST;
      {ier_q, mcr_q, efr_q, feature_control_register_q} <= {4{ufc_pkg::REG_RST}};
      {receive_trigger_register_q, transmit_trigger_register_q, dlm_q, dld_q} <= {4{ufc_pkg::REG_RST}};
      dll_q <= ufc_pkg::DLL_RST;
      fifo_en_q <= 1'b0;
      rx_sel_q <= 2'h0;
      tx_sel_q <= 2'h0;
    end else begin
      if (wr & s_lcr) lcr_q <= wd;
      if (wr & s_efr) efr_q <= wd;
      if (wr & s_feature_control_register) feature_control_register_q <= wd;
      if (wr & s_receive_trigger_register) receive_trigger_register_q <= wd;
      if (wr & s_transmit_trigger_register) transmit_trigger_register_q <= wd;
      if (wr_ier) ier_q <= wd;
      if (wr_dll) dll_q <= wd;
      if (wr_dlm) dlm_q <= wd;
      if (wr_dld) dld_q <= wd;
      if (wr_mcr) begin
        mcr_q[6:0] <= wd[6:0];
        if (efr_q[ufc_pkg::EFR_ENH]) mcr_q[ufc_pkg::MCR_PRESC] <= wd[ufc_pkg::MCR_PRESC];
      end
      if (wr_fcr) fifo_en_q <= wd[ufc_pkg::FCR_EN];
      if (fcr_take) rx_sel_q <= wd[7:6];
      if (fcr_take && efr_q[ufc_pkg::EFR_ENH]) tx_sel_q <= wd[5:4];
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  a_isr_fifo_bits: assert property (rd_isr |=> wb_dat_o[7:6] == {2{$past(fifo_en_q)}})
    else $error("status top bits disagree with FIFO enable");
  a_isr_idle: assert property (rd_isr && isr_code == ufc_pkg::ISR_NONE |=> wb_dat_o[0])
    else $error("pending bit low with no source");
  a_isr_line: assert property (rd_isr && ls_int |=> wb_dat_o[5:0] == ufc_pkg::ISR_LSR)
    else $error("line status not reported first");
  a_fcr_ignore: assert property (wr_fcr && !wd[0] |=> !fifo_en_q && $stable(rx_sel_q))
    else $error("control bits taken without enable");
  a_rx_flush: assert property (rx_flush |=> rx_cnt == 7'h00 && $stable(rx_sh_q))
    else $error("receive flush failed");
  a_tx_flush: assert property (tx_flush |=> tx_cnt == 7'h00 && $stable(tx_sh_q))
    else $error("transmit flush failed");
  a_break_low: assert property (lcr_q.brk [*2] |-> !txd)
    else $error("break did not hold line low");
  a_presc_lock: assert property (wr_mcr && !efr_q[4] |=> $stable(mcr_q[7]))
    else $error("prescaler written while locked");
  a_rx_trigger: assert property (rxr_int |-> isr_code != ufc_pkg::ISR_NONE)
    else $error("receive trigger not reported");
endmodule

`default_nettype wire

// ==== dv/ufc_serial_peer.sv ====
`timescale 1ns/1ns
`default_nettype none
// Remote serial device: drives frames onto rxd and samples frames from txd.
module ufc_serial_peer (
  input wire logic clock,
  input wire logic txd,
  output logic rxd
);
  int cpb = 16; // Clocks per bit; raised by the bench for the slow prescaled rate.
  initial rxd = 1'b1;
  // Bits leave from bit 0 upward, and the line goes back to mark when the frame ends.
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (cpb) @(posedge clock);
    end
    rxd <= 1'b1;
  endtask
  // Mid-bit sampling, so a one-clock lag on txd cannot shift a bit.
  task automatic grab(input int n, output logic [11:0] f, output bit ok);
    int t;
    f = 12'hFFF;
    t = 0;
    while (txd !== 1'b0 && t < 4000) begin
      @(posedge clock);
      t++;
    end
    ok = t < 4000;
    repeat (cpb / 2) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (cpb) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/ufc_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module ufc_top_tb;
  logic clock, resetn, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, rxd, txd;
  logic ms_evt, sp_evt, fl_evt;
  logic [5:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0] rd;
  logic [11:0] fr;
  bit ok;
  int failures = 0;
  int n_tests = 0;
  // Rows: write flag, byte address, then the data written or the value a read expects.
  localparam logic [19:0] ROWS [28] = '{20'h00801, 20'h00C00, 20'h01000, 20'h11080,
    20'h01000, 20'h11810, 20'h11080, 20'h01080, 20'h11000, 20'h10801, 20'h008C1,
    20'h10808, 20'h00801, 20'h10809, 20'h008C1, 20'h1040A, 20'h0040A, 20'h10C83,
    20'h00400, 20'h10005, 20'h00005, 20'h10001, 20'h10C03, 20'h00C03, 20'h10400,
    20'h03C00, 20'h13C55, 20'h03C00};
  localparam logic [7:0] CFG [6] = '{8'h03, 8'h0B, 8'h1A, 8'h29, 8'h3C, 8'h07};
  localparam logic [7:0] DAT [6] = '{8'hA5, 8'h3C, 8'h5B, 8'h2E, 8'h13, 8'hC8};
  localparam logic [7:0] EVT [3] = '{8'hE0, 8'hD0, 8'hC0};

  ufc_top dut (
    .clock(clock), .resetn(resetn), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(4'h1), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd(rxd), .txd(txd),
    .modem_status_evt(ms_evt), .special_char_evt(sp_evt), .flow_pin_evt(fl_evt)
  );
  ufc_serial_peer peer (.clock(clock), .txd(txd), .rxd(rxd));

  // Bench clock, 100 ns period.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // One classic cycle, entered just after an edge; a missing ack ends the run.
  task automatic bus(input logic we, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int t;
    t = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clock);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (t >= 20) begin
      failures++;
      end_sim();
    end
    @(posedge clock);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic rc(input logic [5:0] a, input logic [7:0] e, input string s);
    bus(1'b0, a, 8'h00, rd);
    chk(s, rd, e);
  endtask

  function automatic logic [7:0] msk(input logic [7:0] c);
    return 8'hFF >> (2'h3 - c[1:0]);
  endfunction

  function automatic int nb(input logic [7:0] c);
    return 7 + int'(c[1:0]) + int'(c[3]);
  endfunction

  // Expected line image: start, data from bit 0, optional parity, then mark.
  function automatic logic [11:0] mk(input logic [7:0] d, input logic [7:0] c);
    logic [11:0] f;
    logic p;
    int n;
    n = 5 + int'(c[1:0]);
    f = 12'hFFE;
    p = ^(d & msk(c));
    for (int i = 0; i < n; i++)
      f[i + 1] = d[i];
    if (c[5])
      p = ~c[4];
    else if (!c[4])
      p = ~p;
    if (c[3])
      f[n + 1] = p;
    return f;
  endfunction

  // Below the level nothing is pending; the byte that reaches it raises receive ready.
  task automatic receive_trigger_register(input logic [7:0] feature_control_register, input logic [7:0] fifo_control, input int lvl);
    wr(6'h1C, feature_control_register);
    wr(6'h08, fifo_control);
    for (int i = 0; i < lvl; i++) begin
      if (i == lvl - 1)
        rc(6'h08, 8'hC1, "isr below level");
      peer.send(mk(8'h30, 8'h03), 10);
    end
    rc(6'h08, 8'hC4, "isr at level");
    wr(6'h08, 8'h03);
    rc(6'h08, 8'hC1, "isr after flush");
  endtask

  initial begin
    {resetn, wb_we_i, wb_cyc_i, wb_stb_i, ms_evt, sp_evt, fl_evt} = 7'h00;
    wb_adr_i = 6'h00;
    wb_dat_i = 32'h00000000;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    foreach (ROWS[i]) begin
      bus(ROWS[i][16], ROWS[i][13:8], ROWS[i][7:0], rd);
      if (!ROWS[i][16])
        chk($sformatf("row %0d", i), rd, ROWS[i][7:0]);
    end
    done("registers");
    for (int i = 0; i < 6; i++) begin
      wr(6'h0C, CFG[i]);
      wr(6'h00, DAT[i]);
      peer.grab(nb(CFG[i]), fr, ok);
      chk("tx frame", {ok, fr}, {1'b1, mk(DAT[i], CFG[i])});
      repeat (48) @(posedge clock);
      peer.send(mk(DAT[i], CFG[i]), nb(CFG[i]));
      rc(6'h14, 8'h61, "lsr clean");
      rc(6'h00, DAT[i] & msk(CFG[i]), "rx data");
    end
    wr(6'h0C, 8'h1A);
    peer.send(mk(8'h5B, 8'h1A) ^ 12'h100, 10);
    bus(1'b0, 6'h14, 8'h00, rd);
    chk("parity error", rd & 8'h05, 8'h05);
    rc(6'h00, 8'h5B, "rx bad byte");
    done("frames");
    wr(6'h0C, 8'h03);
    wr(6'h04, 8'h01);
    peer.send(mk(8'h44, 8'h03), 10);
    wr(6'h08, 8'h02); // Flush request without the enable bit.
    bus(1'b0, 6'h14, 8'h00, rd);
    chk("flush ignored", rd[0], 1'b1);
    bus(1'b0, 6'h08, 8'h00, rd);
    chk("fifo off flags", rd & 8'hC0, 8'h00);
    wr(6'h08, 8'h03);
    bus(1'b0, 6'h14, 8'h00, rd);
    chk("rx flushed", rd[0], 1'b0);
    receive_trigger_register(8'h00, 8'h41, 4);
    receive_trigger_register(8'h40, 8'h01, 8);
    receive_trigger_register(8'h80, 8'h41, 16);
    wr(6'h20, 8'h03);
    receive_trigger_register(8'hC0, 8'h01, 3);
    wr(6'h1C, 8'h00);
    done("triggers");
    wr(6'h04, 8'h02);
    wr(6'h00, 8'h5A);
    peer.grab(10, fr, ok);
    chk("tx ready frame", {ok, fr}, {1'b1, mk(8'h5A, 8'h03)});
    rc(6'h08, 8'hC2, "tx ready");
    rc(6'h08, 8'hC1, "tx ready read");
    wr(6'h04, 8'hE8);
    for (int i = 0; i < 3; i++) begin
      {ms_evt, sp_evt, fl_evt} <= 3'((2 << i) - 1);
      repeat (3) @(posedge clock);
      rc(6'h08, EVT[i], "priority");
    end
    {ms_evt, sp_evt, fl_evt} <= 3'h0;
    wr(6'h04, 8'h00);
    done("interrupts");
    wr(6'h0C, 8'h43);
    repeat (3) @(posedge clock);
    chk("break", txd, 1'b0);
    repeat (200) @(posedge clock);
    chk("break held", txd, 1'b0);
    wr(6'h0C, 8'h03);
    repeat (3) @(posedge clock);
    chk("break off", txd, 1'b1);
    wr(6'h10, 8'h80);
    peer.cpb = 64;
    wr(6'h00, 8'h96);
    peer.grab(10, fr, ok);
    chk("prescaled", {ok, fr}, {1'b1, mk(8'h96, 8'h03)});
    peer.cpb = 16;
    wr(6'h10, 8'h00);
    done("line control");
    resetn <= 1'b0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rc(6'h08, 8'h01, "isr after reset");
    rc(6'h0C, 8'h00, "lcr after reset");
    rc(6'h10, 8'h00, "mcr after reset");
    done("reset");
    end_sim();
  end
endmodule
`default_nettype wire
